/* logic/uar_receiver.sv */
/*
 * Asynchronous serial receiver with 16x oversampling, a small receive FIFO with
 * framing and overrun status, 9-bit and address-detect reception, and an AXI4-Lite slave.
 * Assumes rx_in is already synchronous to aclk and idles high.
 */
// Our own choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`include "uar_rx_map.svh"

// Notes on behaviour
// R1 - Falling edge on line starts a character
// R2 - High at half bit aborts silently
// R3 - Each bit centre majority voted, shifted in
// R4 - Stop bit low sets framing error
// R5 - Finished character enters FIFO, ready set
// R6 - Data read returns and removes oldest
// R7 - Ready means enabled and FIFO not empty
// R8 - Ready flag is read only
// R9 - Interrupt needs ready and three enables
// R10 - Framing flag stored per character, shows oldest
// R11 - Framing flag read only, reception continues
// R12 - Port disable clears framing; receive disable not
// R13 - Framing error alone raises no interrupt
// R14 - Third character on full FIFO sets overrun
// R15 - Overrun blocks new characters, old readable
// R16 - Overrun cleared only by receive/port disable
// R17 - Nine-bit mode shifts nine, shows ninth
// R18 - Software reads status before data register
// R19 - Address detect keeps only ninth-bit-set characters
// R20 - Software clears address detect after match
// R21 - Software follows fixed setup order
// R22 - Runs only when enabled, async, port on
// R23 - Recovery at 16x, shifter once per bit
// R24 - Majority of three oversamples round centre
// R25 - Ready drops after emptying read or disable
module uar_receiver
    import uar_rx_pkg::*;
#(
    parameter int FIFO_DEPTH = 2
)(
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write address
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [11:0] s_axi_awaddr,
    // AXI4-Lite write data
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    // AXI4-Lite write response
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output logic [1:0]       s_axi_bresp,
    // AXI4-Lite read address
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [11:0] s_axi_araddr,
    // AXI4-Lite read data
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    // Serial line and events
    input  wire logic        rx_in,
    output logic             rx_ready_flag,
    output logic             rx_irq
);

    localparam int PW = (FIFO_DEPTH > 2) ? $clog2(FIFO_DEPTH) : 1;
    localparam int CW = $clog2(FIFO_DEPTH + 1);

    initial
    begin
        if (FIFO_DEPTH < 2)
        begin
            $error("FIFO_DEPTH must be at least 2");
        end
    end

    // ----------------------------------------------------------------------------
    // State
    // ----------------------------------------------------------------------------
    typedef struct packed {
        uar_rx_state_t                st;
        logic [3:0]                   os_cnt;
        logic [3:0]                   bit_cnt;
        logic [8:0]                   shift;
        logic [2:0]                   samp;
        logic                         rx_prev;
        logic [15:0]                  div_cnt;
        logic [7:0]                   ctrl;
        logic [15:0]                  baud;
        logic [FIFO_DEPTH-1:0][9:0]   mem;
        logic [PW-1:0]                wr_ptr;
        logic [PW-1:0]                rd_ptr;
        logic [CW-1:0]                count;
        logic                         overrun;
        logic                         ready;
        logic                         irq;
        logic                         aw_have;
        logic [11:0]                  awaddr;
        logic                         w_have;
        logic [31:0]                  wdata;
        logic [3:0]                   wstrb;
        logic                         awready;
        logic                         wready;
        logic                         bvalid;
        logic [1:0]                   bresp;
        logic                         arready;
        logic                         rvalid;
        logic [31:0]                  rdata;
        logic [1:0]                   rresp;
    } uar_regs_t;

    uar_regs_t q;
    uar_regs_t d;

    // Value held by at least two of three samples
    function automatic logic maj3(input logic [2:0] s);
        return (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
    endfunction

    function automatic logic [PW-1:0] ptr_next(input logic [PW-1:0] p);
        return (p == PW'(FIFO_DEPTH - 1)) ? '0 : p + PW'(1);
    endfunction

    // ----------------------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------------------
    always_comb
    begin
        logic       port_on;
        logic       rx_en;
        logic       tick;
        logic [2:0] s;
        logic       bit_v;
        logic       push;
        logic       pop;
        logic [9:0] push_word;
        logic [9:0] head;
        logic       wr_go;
        port_on   = 1'b0;
        rx_en     = 1'b0;
        tick      = 1'b0;
        s         = '0;
        bit_v     = 1'b0;
        push      = 1'b0;
        pop       = 1'b0;
        push_word = '0;
        head      = '0;
        wr_go     = 1'b0;
        d         = q;

        port_on = q.ctrl[`UAR_CTRL_PEN_BIT];
        // R22 async enable
        rx_en = port_on & q.ctrl[`UAR_CTRL_REN_BIT] & ~q.ctrl[`UAR_CTRL_SYNC_BIT];
        head  = q.mem[q.rd_ptr];

        // Oversample divider
        // R23 16x recovery tick
        if (rx_en && q.div_cnt == q.baud)
        begin
            tick      = 1'b1;
            d.div_cnt = '0;
        end
        else if (rx_en)
        begin
            d.div_cnt = q.div_cnt + 16'h0001;
        end
        else
        begin
            d.div_cnt = '0;
        end

        // ------------------------------------------------------------------------
        // Receive sequencer
        // ------------------------------------------------------------------------
        if (tick)
        begin
            s         = {q.samp[1:0], rx_in};
            d.samp    = s;
            d.rx_prev = rx_in;
            d.os_cnt  = q.os_cnt + 4'h1;
            unique case (q.st)
                UAR_IDLE:
                begin
                    // R1 start edge
                    // R15 blocked while overrun
                    if (q.rx_prev && !rx_in && !q.overrun)
                    begin
                        d.st     = UAR_START;
                        d.os_cnt = '0;
                    end
                end
                UAR_START:
                begin
                    if (q.os_cnt == `UAR_HALF_BIT_LAST)
                    begin
                        d.os_cnt  = '0;
                        d.bit_cnt = '0;
                        // R2 abort if line high
                        // R24 vote of three
                        d.st      = maj3(s) ? UAR_IDLE : UAR_DATA;
                    end
                end
                UAR_DATA:
                begin
                    if (q.os_cnt == `UAR_FULL_BIT_LAST)
                    begin
                        // R3 centre sample shifted in
                        bit_v     = maj3(s);
                        d.shift   = {bit_v, q.shift[8:1]};
                        d.os_cnt  = '0;
                        d.bit_cnt = q.bit_cnt + 4'h1;
                        // R17 nine bits when selected
                        if (d.bit_cnt == (q.ctrl[`UAR_CTRL_N9_BIT] ? `UAR_BITS_9 : `UAR_BITS_8))
                        begin
                            d.st = UAR_STOP;
                        end
                    end
                end
                UAR_STOP:
                begin
                    if (q.os_cnt == `UAR_FULL_BIT_LAST)
                    begin
                        d.os_cnt = '0;
                        d.st     = UAR_IDLE;
                        // R4 stop low means framing error
                        // R10 flag stored with character
                        push_word[9]   = ~maj3(s);
                        push_word[8:0] = q.ctrl[`UAR_CTRL_N9_BIT] ? q.shift : {1'b0, q.shift[8:1]};
                        // R19 address filter
                        // R11 reception continues on error
                        push = !(q.ctrl[`UAR_CTRL_ADR_BIT] && q.ctrl[`UAR_CTRL_N9_BIT] && !push_word[8]);
                    end
                end
            endcase
        end

        // ------------------------------------------------------------------------
        // AXI4-Lite write
        // ------------------------------------------------------------------------
        if (s_axi_awvalid && q.awready)
        begin
            d.aw_have = 1'b1;
            d.awaddr  = s_axi_awaddr;
        end
        if (s_axi_wvalid && q.wready)
        begin
            d.w_have = 1'b1;
            d.wdata  = s_axi_wdata;
            d.wstrb  = s_axi_wstrb;
        end
        if (q.bvalid && s_axi_bready)
        begin
            d.bvalid = 1'b0;
        end
        wr_go = q.aw_have && q.w_have && !q.bvalid;
        if (wr_go)
        begin
            d.aw_have = 1'b0;
            d.w_have  = 1'b0;
            d.bvalid  = 1'b1;
            d.bresp   = `UAR_RESP_OKAY;
            unique case (q.awaddr)
                `UAR_OFS_CTRL:
                begin
                    if (q.wstrb[0])
                    begin
                        d.ctrl = q.wdata[7:0];
                    end
                end
                `UAR_OFS_BAUD:
                begin
                    if (q.wstrb[0])
                    begin
                        d.baud[7:0] = q.wdata[7:0];
                    end
                    if (q.wstrb[1])
                    begin
                        d.baud[15:8] = q.wdata[15:8];
                    end
                end
                // R8 status writes ignored
                `UAR_OFS_STATUS, `UAR_OFS_DATA:
                begin
                end
                default:
                begin
                    d.bresp = `UAR_RESP_DECERR;
                end
            endcase
        end
        d.awready = !d.aw_have && !d.bvalid;
        d.wready  = !d.w_have && !d.bvalid;

        // ------------------------------------------------------------------------
        // AXI4-Lite read
        // ------------------------------------------------------------------------
        if (q.rvalid && s_axi_rready)
        begin
            d.rvalid = 1'b0;
        end
        if (s_axi_arvalid && q.arready)
        begin
            d.rvalid = 1'b1;
            d.rresp  = `UAR_RESP_OKAY;
            d.rdata  = '0;
            unique case (s_axi_araddr)
                `UAR_OFS_CTRL:
                begin
                    d.rdata[7:0] = q.ctrl;
                end
                `UAR_OFS_BAUD:
                begin
                    d.rdata[15:0] = q.baud;
                end
                `UAR_OFS_STATUS:
                begin
                    d.rdata[`UAR_STAT_READY_BIT] = q.ready;
                    d.rdata[`UAR_STAT_FRM_BIT]   = (q.count != '0) & head[9];
                    d.rdata[`UAR_STAT_OVR_BIT]   = q.overrun;
                    d.rdata[`UAR_STAT_NINTH_BIT] = (q.count != '0) & head[8];
                    d.rdata[`UAR_STAT_IDLE_BIT]  = (q.st == UAR_IDLE);
                end
                `UAR_OFS_DATA:
                begin
                    // R6 read pops oldest
                    d.rdata[8:0] = (q.count != '0) ? head[8:0] : 9'h000;
                    pop          = (q.count != '0);
                end
                default:
                begin
                    d.rresp = `UAR_RESP_DECERR;
                end
            endcase
        end
        d.arready = !d.rvalid;

        // ------------------------------------------------------------------------
        // FIFO
        // ------------------------------------------------------------------------
        // R14 full on completion sets overrun
        if (push && q.count == CW'(FIFO_DEPTH) && !pop)
        begin
            push      = 1'b0;
            d.overrun = 1'b1;
        end
        // R5 character enters FIFO
        if (push)
        begin
            d.mem[q.wr_ptr] = push_word;
            d.wr_ptr        = ptr_next(q.wr_ptr);
        end
        if (pop)
        begin
            d.rd_ptr = ptr_next(q.rd_ptr);
        end
        d.count = q.count + CW'(push) - CW'(pop);

        // ------------------------------------------------------------------------
        // Disables
        // ------------------------------------------------------------------------
        if (!rx_en)
        begin
            d.st     = UAR_IDLE;
            d.os_cnt = '0;
            d.samp   = 3'b111;
            d.rx_prev = 1'b1;
        end
        // R16 overrun cleared by receive disable
        if (!q.ctrl[`UAR_CTRL_REN_BIT])
        begin
            d.overrun = 1'b0;
        end
        // R12 port disable flushes, clears framing
        if (!port_on)
        begin
            d.overrun = 1'b0;
            d.count   = '0;
            d.wr_ptr  = '0;
            d.rd_ptr  = '0;
        end

        // R7 ready follows FIFO and enable
        // R25 drops after last read or disable
        d.ready = rx_en && (d.count != '0);
        // R9 four-way interrupt gate
        // R13 framing not in the gate
        d.irq   = d.ready && d.ctrl[`UAR_CTRL_RXIE_BIT] && d.ctrl[`UAR_CTRL_PIE_BIT]
                  && d.ctrl[`UAR_CTRL_GLB_BIT];
    end

    // ----------------------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            q         <= '0;
            q.st      <= UAR_IDLE;
            q.samp    <= 3'b111;
            q.rx_prev <= 1'b1;
            q.ctrl    <= `UAR_CTRL_RESET;
            q.baud    <= `UAR_BAUD_RESET;
        end
        else
        begin
            q <= d;
        end
    end

    assign s_axi_awready = q.awready;
    assign s_axi_wready  = q.wready;
    assign s_axi_bvalid  = q.bvalid;
    assign s_axi_bresp   = q.bresp;
    assign s_axi_arready = q.arready;
    assign s_axi_rvalid  = q.rvalid;
    assign s_axi_rdata   = q.rdata;
    assign s_axi_rresp   = q.rresp;
    assign rx_ready_flag = q.ready;
    assign rx_irq        = q.irq;

endmodule // uar_receiver

/* logic/uar_rx_map.svh */
/*
 * Register offsets, field positions, reset values and timing counts of the asynchronous receiver.
 * Assumes byte addressing on a 32-bit AXI4-Lite bus, one aligned word per register.
 */
`ifndef UAR_RX_MAP_SVH
`define UAR_RX_MAP_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define UAR_OFS_CTRL        12'h000
`define UAR_OFS_BAUD        12'h004
`define UAR_OFS_STATUS      12'h008
`define UAR_OFS_DATA        12'h00c

// ----------------------------------------------------------------------------
// Control register fields (rx_status_ctrl_reg and enables)
// ----------------------------------------------------------------------------
`define UAR_CTRL_PEN_BIT    0
`define UAR_CTRL_REN_BIT    1
`define UAR_CTRL_N9_BIT     2
`define UAR_CTRL_ADR_BIT    3
`define UAR_CTRL_SYNC_BIT   4
`define UAR_CTRL_RXIE_BIT   5
`define UAR_CTRL_PIE_BIT    6
`define UAR_CTRL_GLB_BIT    7
`define UAR_CTRL_RESET      8'h00

// ----------------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------------
`define UAR_STAT_READY_BIT  0
`define UAR_STAT_FRM_BIT    1
`define UAR_STAT_OVR_BIT    2
`define UAR_STAT_NINTH_BIT  3
`define UAR_STAT_IDLE_BIT   4

// ----------------------------------------------------------------------------
// Baud divisor: one oversample tick every (divisor + 1) clocks
// ----------------------------------------------------------------------------
`define UAR_BAUD_RESET      16'h0000

// ----------------------------------------------------------------------------
// Oversampling counts (16 ticks per bit)
// ----------------------------------------------------------------------------
`define UAR_OVERSAMPLE      16
`define UAR_HALF_BIT_LAST   4'h7
`define UAR_FULL_BIT_LAST   4'hf
`define UAR_BITS_8          4'h8
`define UAR_BITS_9          4'h9

// ----------------------------------------------------------------------------
// AXI responses
// ----------------------------------------------------------------------------
`define UAR_RESP_OKAY       2'b00
`define UAR_RESP_DECERR     2'b11

`endif

/* logic/uar_rx_pkg.sv */
/*
 * Types of the asynchronous receiver.
 * Assumes uar_rx_map.svh is on the include path.
 */
package uar_rx_pkg;

    // Receive sequencer states, one-hot
    typedef enum logic [3:0] {
        UAR_IDLE  = 4'b0001,
        UAR_START = 4'b0010,
        UAR_DATA  = 4'b0100,
        UAR_STOP  = 4'b1000
    } uar_rx_state_t;

endpackage

/* verif/uar_line_model.sv */
/*
 * Remote serial transmitter driving the receive line, LSB first, one stop bit.
 * Assumes BIT_CLKS matches the receiver's programmed bit period in aclk cycles.
 */
`timescale 1ns/1ps
module uar_line_model #(
    parameter int BIT_CLKS = 32
)(
    // Clock
    input wire logic aclk,
    // Serial line
    output logic     rx_in
);
    initial rx_in = 1'b1;

    task automatic send(input logic [8:0] d, input int nb, input logic stop);
        int i;
        rx_in <= 1'b0;
        repeat (BIT_CLKS) @(posedge aclk);
        for (i = 0; i < nb; i++)
        begin
            rx_in <= d[i];
            repeat (BIT_CLKS) @(posedge aclk);
        end
        rx_in <= stop;
        repeat (BIT_CLKS) @(posedge aclk);
        rx_in <= 1'b1;
        repeat (BIT_CLKS) @(posedge aclk);
    endtask

    task automatic glitch(input int n);
        rx_in <= 1'b0;
        repeat (n) @(posedge aclk);
        rx_in <= 1'b1;
        repeat (BIT_CLKS * 12) @(posedge aclk);
    endtask
endmodule // uar_line_model

/* verif/uar_rx_properties.sv */
/*
 * Concurrent checks on the receiver's bus handshakes and event outputs.
 * Assumes one clock domain with a synchronous active-low reset; bound to uar_receiver.
 */
`timescale 1ns/1ps
module uar_rx_properties #(
    parameter int FIFO_DEPTH = 2
)(
    // Clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // Write channels
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [1:0]  s_axi_bresp,
    // Read channels
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    // Events
    input wire logic        rx_ready_flag,
    input wire logic        rx_irq
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence

    a_write_answer: assert property (s_wr_taken |=> !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("write response not on time");
    a_read_answer: assert property (s_rd_taken |=> s_axi_rvalid)
        else $error("read data not on time");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
                                   s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read data dropped early");
    a_read_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read data repeated");
    a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while data pending");
    a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    a_irq_gating: assert property (rx_irq |-> rx_ready_flag || $past(rx_ready_flag))
        else $error("interrupt without ready flag");
    a_ready_fall: assert property ($fell(rx_ready_flag) |-> s_axi_rvalid || $past(s_axi_rvalid)
                                   || s_axi_bvalid || $past(s_axi_bvalid))
        else $error("ready flag dropped without read or disable");
endmodule // uar_rx_properties

bind uar_receiver uar_rx_properties #(.FIFO_DEPTH(FIFO_DEPTH)) u_props (.*);

/* verif/uart_async_receiver_tb.sv */
/*
 * Self-checking bench of the receiver: bus tasks, random and corner frames.
 * Assumes the line model drives rx_in and the checker is bound.
 */
`timescale 1ns/1ps
`include "uar_rx_map.svh"
module uart_async_receiver_tb;
    localparam logic [31:0] BAUD_DIV = 32'h1;
    localparam int BIT_CLKS = 16 * (BAUD_DIV + 1);
    localparam logic [31:0] ON = (32'h1 << `UAR_CTRL_PEN_BIT) | (32'h1 << `UAR_CTRL_REN_BIT),
        SP = 32'h1 << `UAR_CTRL_PEN_BIT,
        IRQ = 32'h7 << `UAR_CTRL_RXIE_BIT,
        N9 = 32'h1 << `UAR_CTRL_N9_BIT,
        ADD = 32'h1 << `UAR_CTRL_ADR_BIT,
        SYN = 32'h1 << `UAR_CTRL_SYNC_BIT,
        SM = ~(32'h1 << `UAR_STAT_IDLE_BIT),
        OK = 32'(`UAR_RESP_OKAY),
        DEC = 32'(`UAR_RESP_DECERR);

    logic        aclk = 1'b0;
    logic        aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic        rx_in, rx_ready_flag, rx_irq;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
    logic [3:0]  s_axi_wstrb;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, seed, stl, rv;
    int          num_errors, cmp_count, k;

    uar_receiver #(.FIFO_DEPTH(2)) dut (
        .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
        .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
        .rx_in, .rx_ready_flag, .rx_irq
    );
    uar_line_model #(.BIT_CLKS(BIT_CLKS)) tx (.aclk, .rx_in);

    always #5 aclk = ~aclk;

    // Random response stalls
    always @(posedge aclk)
    begin
        stl <= lfsr(stl);
        if (!s_axi_bready || s_axi_bvalid) s_axi_bready <= stl[3];
        if (!s_axi_rready || s_axi_rvalid) s_axi_rready <= stl[7];
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [31:0] stat(input logic r, f, o, n);
        stat = (32'(r) << `UAR_STAT_READY_BIT) | (32'(f) << `UAR_STAT_FRM_BIT)
               | (32'(o) << `UAR_STAT_OVR_BIT) | (32'(n) << `UAR_STAT_NINTH_BIT);
    endfunction

    task automatic complete_run();
        if (num_errors == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, exp);
        cmp_count++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic guard(input int n);
        if (n >= 64)
        begin
            num_errors++;
            complete_run();
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d, rsp);
        int n;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        for (n = 0; n < 64; n++)
        begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && s_axi_bready) break;
        end
        guard(n);
        chk("bresp", 32'(s_axi_bresp), rsp);
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        for (n = 0; n < 64; n++)
        begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && s_axi_rready) break;
        end
        guard(n);
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask

    task automatic rc(input logic [11:0] a, input logic [31:0] m, e, input string nm);
        logic [31:0] d;
        rd(a, d, rs);
        chk(nm, d & m, e);
    endtask

    task automatic st(input logic r, f, o, n);
        rc(`UAR_OFS_STATUS, SM, stat(r, f, o, n), "status");
    endtask

    task automatic dt(input logic [31:0] e);
        rc(`UAR_OFS_DATA, 32'h1ff, e, "data");
    endtask

    task automatic cw(input logic [31:0] c);
        wr(`UAR_OFS_CTRL, c, OK);
    endtask

    initial
    begin
        aresetn <= 1'b0;
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        s_axi_arvalid <= 1'b0;
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
        s_axi_wstrb <= 4'hf;
        seed = 32'h3a14;
        stl = 32'h3a14;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rc(`UAR_OFS_CTRL, 32'hff, 32'h0, "ctrl");
        rc(`UAR_OFS_BAUD, 32'hffff, 32'h0, "baud");
        wr(12'h010, 32'hff, DEC);
        rd(12'h010, rv, rs);
        chk("rresp", 32'(rs), DEC);
        wr(`UAR_OFS_BAUD, BAUD_DIV, OK);
        rc(`UAR_OFS_BAUD, 32'hffff, BAUD_DIV, "baud");
        cw(ON | SYN);
        tx.send(9'h05a, 8, 1'b1);
        st(1'b0, 1'b0, 1'b0, 1'b0);
        cw(ON | IRQ);
        wr(`UAR_OFS_STATUS, 32'h1f, OK);
        st(1'b0, 1'b0, 1'b0, 1'b0);
        for (k = 0; k < 4; k++)
        begin
            seed = lfsr(seed);
            tx.send({1'b0, seed[7:0]}, 8, 1'b1);
            chk("irq", 32'(rx_irq), 32'h1);
            st(1'b1, 1'b0, 1'b0, 1'b0);
            dt({24'h0, seed[7:0]});
            repeat (2) @(posedge aclk);
            chk("ready", 32'(rx_ready_flag), 32'h0);
        end
        tx.glitch(BIT_CLKS / 4);
        st(1'b0, 1'b0, 1'b0, 1'b0);
        dt(32'h0);
        cw(ON);
        tx.send(9'h055, 8, 1'b0);
        tx.send(9'h0a3, 8, 1'b1);
        chk("irq", 32'(rx_irq), 32'h0);
        st(1'b1, 1'b1, 1'b0, 1'b0);
        for (k = 0; k < 4; k++)
        begin
            cw(ON | (IRQ & ~(32'h1 << (`UAR_CTRL_RXIE_BIT + k))));
            chk("irq", 32'(rx_irq), 32'(k == 3));
        end
        chk("irq", 32'(rx_irq), 32'h1);
        cw(ON | (32'h3 << `UAR_CTRL_PIE_BIT));
        chk("irq", 32'(rx_irq), 32'h0);
        dt(32'h055);
        st(1'b1, 1'b0, 1'b0, 1'b0);
        dt(32'h0a3);
        cw(ON);
        tx.send(9'h07e, 8, 1'b1);
        tx.send(9'h081, 8, 1'b0);
        tx.send(9'h000, 8, 1'b1);
        st(1'b1, 1'b0, 1'b1, 1'b0);
        tx.send(9'h0ff, 8, 1'b1);
        dt(32'h07e);
        st(1'b1, 1'b1, 1'b1, 1'b0);
        cw(SP);
        st(1'b0, 1'b1, 1'b0, 1'b0);
        cw(ON);
        dt(32'h081);
        tx.send(9'h03c, 8, 1'b1);
        dt(32'h03c);
        tx.send(9'h0c5, 8, 1'b0);
        st(1'b1, 1'b1, 1'b0, 1'b0);
        cw(32'h0);
        st(1'b0, 1'b0, 1'b0, 1'b0);
        cw(ON | N9 | ADD);
        dt(32'h0);
        tx.send(9'h0aa, 9, 1'b1);
        st(1'b0, 1'b0, 1'b0, 1'b0);
        tx.send(9'h1c5, 9, 1'b1);
        st(1'b1, 1'b0, 1'b0, 1'b1);
        dt(32'h1c5);
        cw(ON | N9);
        tx.send(9'h033, 9, 1'b1);
        st(1'b1, 1'b0, 1'b0, 1'b0);
        dt(32'h033);
        complete_run();
    end
endmodule // uart_async_receiver_tb
